//--- src/ljs_pkg.sv
// Package for the laser job I/O sequencer: register map, fields, timing.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package ljs_pkg;

  // Clock rate and the millisecond tick derived from it
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] POWER_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] START_WIDTH_OFS = 8'h14;
  localparam logic [7:0] START_DELAY_OFS = 8'h18;
  localparam logic [7:0] LEAD_OFS = 8'h1c;
  localparam logic [7:0] STOP_WIDTH_OFS = 8'h20;
  localparam logic [7:0] FIN_DELAY_OFS = 8'h24;
  localparam logic [7:0] FIN_WIDTH_OFS = 8'h28;
  localparam logic [7:0] CMD_OFS = 8'h2c;

  // Control register fields
  localparam int CTRL_FW_ALIVE = 0;
  localparam int CTRL_BUF_FULL = 1;
  localparam int CTRL_SW_READY = 2;
  localparam int CTRL_EMIT_REQ = 3;
  localparam int CTRL_PULSE_EN = 4;
  localparam int CTRL_BOARD_FAIL = 5;
  localparam int CTRL_HEAD_FAIL = 6;
  localparam int CTRL_GREEN = 7;

  // Command register fields, write-one pulses
  localparam int CMD_CONFIRM = 0;
  localparam int CMD_REJECT = 1;
  localparam int CMD_DONE = 2;

  // Interrupt status fields
  localparam int IRQ_START_REQ = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_FINISHED = 2;
  localparam int IRQ_MARK_BEGIN = 3;
  localparam int IRQ_W = 4;

  // Widths and reset values
  localparam int POWER_W = 12;
  localparam int IVL_W = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [POWER_W-1:0] POWER_RST = 12'h000;
  localparam logic [IVL_W-1:0] IVL_RST = 16'h0001;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // Sequencer states, Gray along idle-pending-delay-mark-findelay-fin
  typedef enum logic [2:0] {
    LJS_IDLE = 3'b000,
    LJS_PEND = 3'b001,
    LJS_DELAY = 3'b011,
    LJS_MARK = 3'b010,
    LJS_FDLY = 3'b110,
    LJS_FIN = 3'b111
  } ljs_state_e;

  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ljs_apb_req_s;

  // Laser source drive carrier
  typedef struct packed {
    logic emitGate;
    logic pulseModN;
    logic [POWER_W-1:0] powerLevel;
  } ljs_laser_s;

endpackage

//--- src/ljs_sequencer.sv
// Laser job I/O sequencer: laser drive, external start/stop, job status
// outputs, LEDs and an APB register file with interrupt.
// Assumes start/stop inputs already synchronous to clk.
//
// How it works
// - Emission gate high active, pulse line low active
// - Twelve-bit power value held for converter
// - Valid start flagged when idle and armed; marking waits software confirm
// - Armed output when buffer full, software ready
// - Active output while command buffer executes
// - Alive output only while firmware reports running
// - All intervals programmed in one-millisecond steps
// - Start valid only after minimum start width
// - Confirmed start waits programmed start delay
// - Active output leads marking by lead interval
// - Stop halts only after minimum stop width
// - Finished output after delay from emission end
// - Finished output lasts programmed width, then drops
// - Red LED steady on board failure
// - Red LED blinks irregularly on head failure
`timescale 1ns/100ps
module ljs_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire ljs_pkg::ljs_apb_req_s apbReq,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic extStart,
  input wire logic extStop,
  output ljs_pkg::ljs_laser_s laser,
  output logic jobArmed,
  output logic markActive,
  output logic jobFinished,
  output logic fwAlive,
  output logic ledRed,
  output logic ledGreen,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [31:0] ctrl_ff;
  logic [ljs_pkg::POWER_W-1:0] power_ff;
  logic [ljs_pkg::IRQ_W-1:0] irqStat_ff;
  logic [ljs_pkg::IRQ_W-1:0] irqMask_ff;
  logic [ljs_pkg::IVL_W-1:0] ivl_ff [6];
  logic [15:0] tickCnt_ff;
  logic tick;
  logic [ljs_pkg::IVL_W-1:0] startCnt_ff;
  logic [ljs_pkg::IVL_W-1:0] stopCnt_ff;
  logic [ljs_pkg::IVL_W-1:0] seqCnt_ff;
  logic [ljs_pkg::IVL_W-1:0] leadCnt_ff;
  logic startValid;
  logic stopValid;
  logic startSeen_ff;
  logic stopSeen_ff;
  ljs_pkg::ljs_state_e state_ff;
  ljs_pkg::ljs_state_e nxt_state;
  logic [15:0] lfsr_ff;
  logic [ljs_pkg::IRQ_W-1:0] evt;
  logic wrEn;
  logic cmdConfirm;
  logic cmdReject;
  logic cmdDone;

  // Interval index into ivl_ff
  localparam int I_SW = 0;
  localparam int I_SD = 1;
  localparam int I_LD = 2;
  localparam int I_PW = 3;
  localparam int I_FD = 4;
  localparam int I_FW = 5;

  // Index of interval register for an address, or 7 when none
  function automatic logic [2:0] ivlIdx(input logic [7:0] a);
    case (a)
      ljs_pkg::START_WIDTH_OFS: ivlIdx = 3'd0;
      ljs_pkg::START_DELAY_OFS: ivlIdx = 3'd1;
      ljs_pkg::LEAD_OFS: ivlIdx = 3'd2;
      ljs_pkg::STOP_WIDTH_OFS: ivlIdx = 3'd3;
      ljs_pkg::FIN_DELAY_OFS: ivlIdx = 3'd4;
      ljs_pkg::FIN_WIDTH_OFS: ivlIdx = 3'd5;
      default: ivlIdx = 3'd7;
    endcase
  endfunction

  // Address is one of the mapped registers
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == ljs_pkg::CTRL_OFS) || (a == ljs_pkg::POWER_OFS) ||
      (a == ljs_pkg::STATUS_OFS) || (a == ljs_pkg::IRQ_STAT_OFS) ||
      (a == ljs_pkg::IRQ_MASK_OFS) || (a == ljs_pkg::CMD_OFS) ||
      (ivlIdx(a) != 3'd7);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = apbReq.psel && apbReq.penable && !isMapped(apbReq.paddr);
  assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite &&
    isMapped(apbReq.paddr);
  assign cmdConfirm = wrEn && apbReq.paddr == ljs_pkg::CMD_OFS &&
    apbReq.pwdata[ljs_pkg::CMD_CONFIRM];
  assign cmdReject = wrEn && apbReq.paddr == ljs_pkg::CMD_OFS &&
    apbReq.pwdata[ljs_pkg::CMD_REJECT];
  assign cmdDone = wrEn && apbReq.paddr == ljs_pkg::CMD_OFS &&
    apbReq.pwdata[ljs_pkg::CMD_DONE];

  // Control, power and interval registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= ljs_pkg::CTRL_RST;
      power_ff <= ljs_pkg::POWER_RST;
      irqMask_ff <= '0;
      for (int i = 0; i < 6; i++) begin
        ivl_ff[i] <= ljs_pkg::IVL_RST;
      end
    end else if (wrEn) begin
      case (apbReq.paddr)
        ljs_pkg::CTRL_OFS: ctrl_ff <= {24'h000000, apbReq.pwdata[7:0]};
        ljs_pkg::POWER_OFS: begin
          power_ff <= apbReq.pwdata[ljs_pkg::POWER_W-1:0];
        end
        ljs_pkg::IRQ_MASK_OFS: begin
          irqMask_ff <= apbReq.pwdata[ljs_pkg::IRQ_W-1:0];
        end
        default: begin
          if (ivlIdx(apbReq.paddr) != 3'd7) begin
            ivl_ff[ivlIdx(apbReq.paddr)] <=
              apbReq.pwdata[ljs_pkg::IVL_W-1:0];
          end
        end
      endcase
    end
  end

  // Read data mux, registered on the setup phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
      case (apbReq.paddr)
        ljs_pkg::CTRL_OFS: prdata <= ctrl_ff;
        ljs_pkg::POWER_OFS: prdata <= {20'h00000, power_ff};
        ljs_pkg::STATUS_OFS: begin
          prdata <= {25'h0, state_ff, jobFinished, markActive,
            jobArmed, laser.emitGate};
        end
        ljs_pkg::IRQ_STAT_OFS: prdata <= {28'h0000000, irqStat_ff};
        ljs_pkg::IRQ_MASK_OFS: prdata <= {28'h0000000, irqMask_ff};
        default: begin
          if (ivlIdx(apbReq.paddr) != 3'd7) begin
            prdata <= {16'h0000, ivl_ff[ivlIdx(apbReq.paddr)]};
          end else begin
            prdata <= '0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick; intervals count in ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tickCnt_ff <= '0;
    end else if (tick) begin
      tickCnt_ff <= '0;
    end else begin
      tickCnt_ff <= tickCnt_ff + 16'h0001;
    end
  end
  assign tick = tickCnt_ff == 16'(ljs_pkg::TICK_CYCLES - 1);

  // Width filters on start and stop, each independent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startCnt_ff <= '0;
      stopCnt_ff <= '0;
    end else begin
      if (!extStart) begin
        startCnt_ff <= '0;
      end else if (tick && !startValid) begin
        startCnt_ff <= startCnt_ff + 16'h0001;
      end
      if (!extStop) begin
        stopCnt_ff <= '0;
      end else if (tick && !stopValid) begin
        stopCnt_ff <= stopCnt_ff + 16'h0001;
      end
    end
  end
  assign startValid = extStart && startCnt_ff >= ivl_ff[I_SW];
  assign stopValid = extStop && stopCnt_ff >= ivl_ff[I_PW];

  // One acceptance per held assertion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startSeen_ff <= 1'b0;
      stopSeen_ff <= 1'b0;
    end else begin
      startSeen_ff <= startValid;
      stopSeen_ff <= stopValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Job sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ljs_pkg::LJS_IDLE: begin
        if (startValid && !startSeen_ff && jobArmed) begin
          nxt_state = ljs_pkg::LJS_PEND;
        end
      end
      ljs_pkg::LJS_PEND: begin
        if (cmdReject) begin
          nxt_state = ljs_pkg::LJS_IDLE;
        end else if (cmdConfirm) begin
          nxt_state = ljs_pkg::LJS_DELAY;
        end
      end
      ljs_pkg::LJS_DELAY: begin
        if (stopValid) begin
          nxt_state = ljs_pkg::LJS_FDLY;
        end else if (tick && seqCnt_ff >= ivl_ff[I_SD]) begin
          nxt_state = ljs_pkg::LJS_MARK;
        end
      end
      ljs_pkg::LJS_MARK: begin
        if (stopValid || cmdDone) begin
          nxt_state = ljs_pkg::LJS_FDLY;
        end
      end
      ljs_pkg::LJS_FDLY: begin
        if (tick && seqCnt_ff >= ivl_ff[I_FD]) begin
          nxt_state = ljs_pkg::LJS_FIN;
        end
      end
      ljs_pkg::LJS_FIN: begin
        if (tick && seqCnt_ff >= ivl_ff[I_FW]) begin
          nxt_state = ljs_pkg::LJS_IDLE;
        end
      end
      default: nxt_state = ljs_pkg::LJS_IDLE;
    endcase
  end

  // State and interval counter, counter restarts on every state change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ljs_pkg::LJS_IDLE;
      seqCnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        seqCnt_ff <= '0;
      end else if (tick) begin
        seqCnt_ff <= seqCnt_ff + 16'h0001;
      end
    end
  end

  // Lead counter: active rises this many ms before marking starts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      leadCnt_ff <= '0;
    end else if (state_ff != ljs_pkg::LJS_DELAY) begin
      leadCnt_ff <= '0;
    end else if (tick) begin
      leadCnt_ff <= seqCnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status and laser outputs, registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      jobArmed <= 1'b0;
      markActive <= 1'b0;
      jobFinished <= 1'b0;
      fwAlive <= 1'b0;
      laser <= '{emitGate: 1'b0, pulseModN: 1'b1, powerLevel: '0};
    end else begin
      jobArmed <= ctrl_ff[ljs_pkg::CTRL_BUF_FULL] &&
        ctrl_ff[ljs_pkg::CTRL_SW_READY];
      markActive <= (state_ff == ljs_pkg::LJS_MARK) ||
        (state_ff == ljs_pkg::LJS_DELAY &&
         leadCnt_ff + ivl_ff[I_LD] >= ivl_ff[I_SD]);
      jobFinished <= state_ff == ljs_pkg::LJS_FIN;
      fwAlive <= ctrl_ff[ljs_pkg::CTRL_FW_ALIVE];
      laser.emitGate <= state_ff == ljs_pkg::LJS_MARK &&
        ctrl_ff[ljs_pkg::CTRL_EMIT_REQ];
      laser.pulseModN <= !(state_ff == ljs_pkg::LJS_MARK &&
        ctrl_ff[ljs_pkg::CTRL_PULSE_EN]);
      laser.powerLevel <= power_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // LEDs: steady red on board fault, pseudo-random blink on head fault
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_ff <= ljs_pkg::LFSR_SEED;
      ledRed <= 1'b0;
      ledGreen <= 1'b0;
    end else begin
      if (tick) begin
        lfsr_ff <= {lfsr_ff[14:0],
          lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      end
      ledRed <= ctrl_ff[ljs_pkg::CTRL_BOARD_FAIL] ||
        (ctrl_ff[ljs_pkg::CTRL_HEAD_FAIL] && lfsr_ff[0]);
      ledGreen <= ctrl_ff[ljs_pkg::CTRL_GREEN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one clear
  assign evt[ljs_pkg::IRQ_START_REQ] = state_ff == ljs_pkg::LJS_IDLE &&
    nxt_state == ljs_pkg::LJS_PEND;
  assign evt[ljs_pkg::IRQ_STOPPED] = stopValid && !stopSeen_ff;
  assign evt[ljs_pkg::IRQ_FINISHED] = state_ff == ljs_pkg::LJS_FDLY &&
    nxt_state == ljs_pkg::LJS_FIN;
  assign evt[ljs_pkg::IRQ_MARK_BEGIN] = state_ff == ljs_pkg::LJS_DELAY &&
    nxt_state == ljs_pkg::LJS_MARK;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_ff <= '0;
    end else begin
      irqStat_ff <= (irqStat_ff & ~((wrEn &&
        apbReq.paddr == ljs_pkg::IRQ_STAT_OFS) ?
        apbReq.pwdata[ljs_pkg::IRQ_W-1:0] : '0)) | evt;
    end
  end
  assign irq = |(irqStat_ff & irqMask_ff);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence confirmSeq;
    state_ff == ljs_pkg::LJS_PEND && cmdConfirm;
  endsequence

  pulse_polarity_a: assert property (
    @(posedge clk) disable iff (!resetn)
    laser.emitGate || !laser.pulseModN |->
    $past(state_ff) == ljs_pkg::LJS_MARK)
    else $error("Emission or pulse outside marking");
  power_follow_a: assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 laser.powerLevel == $past(power_ff))
    else $error("Power level not following register");
  start_confirm_a: assert property (
    @(posedge clk) disable iff (!resetn)
    state_ff == ljs_pkg::LJS_PEND && !cmdConfirm && !cmdReject |=>
    state_ff == ljs_pkg::LJS_PEND)
    else $error("Start left pending without confirm");
  confirm_delay_a: assert property (
    @(posedge clk) disable iff (!resetn)
    confirmSeq |=> state_ff == ljs_pkg::LJS_DELAY)
    else $error("Confirm did not enter start delay");
  armed_out_a: assert property (
    @(posedge clk) disable iff (!resetn)
    ctrl_ff[ljs_pkg::CTRL_BUF_FULL] && ctrl_ff[ljs_pkg::CTRL_SW_READY] |=>
    jobArmed)
    else $error("Armed output missing");
  active_mark_a: assert property (
    @(posedge clk) disable iff (!resetn)
    state_ff == ljs_pkg::LJS_MARK |=> markActive)
    else $error("Active output low while marking");
  alive_out_a: assert property (
    @(posedge clk) disable iff (!resetn)
    fwAlive == $past(ctrl_ff[ljs_pkg::CTRL_FW_ALIVE]))
    else $error("Alive output wrong");
  start_width_a: assert property (
    @(posedge clk) disable iff (!resetn)
    evt[ljs_pkg::IRQ_START_REQ] |-> startCnt_ff >= ivl_ff[I_SW])
    else $error("Start accepted too short");
  stop_width_a: assert property (
    @(posedge clk) disable iff (!resetn)
    state_ff == ljs_pkg::LJS_MARK && !stopValid && !cmdDone |=>
    state_ff == ljs_pkg::LJS_MARK)
    else $error("Marking halted without valid stop");
  finish_pulse_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(jobFinished) |-> $past(state_ff, 2) == ljs_pkg::LJS_FDLY)
    else $error("Finished raised without finish delay");
  red_fail_a: assert property (
    @(posedge clk) disable iff (!resetn)
    ctrl_ff[ljs_pkg::CTRL_BOARD_FAIL] |=> ledRed)
    else $error("Red LED not on for board failure");

endmodule

//--- tb/ljs_machine_model.sv
// Model of the external machine controller and the laser source.
// Assumes the bench asks for start/stop levels; clk is the board clock.
`timescale 1ns/100ps
module ljs_machine_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wantStart,
  input wire logic wantStop,
  input wire ljs_pkg::ljs_laser_s laser,
  output logic extStart,
  output logic extStop,
  output logic emitSeen
);
  ////////////////////////////////////////////////////////////////////////
  // Two separate request lines, each a plain level of its own
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extStart <= 1'b0;
      extStop <= 1'b0;
    end else begin
      extStart <= wantStart;
      extStop <= wantStop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Laser source: remembers that the beam really fired, gate high with
  // the pulse switch opened by a low level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      emitSeen <= 1'b0;
    end else if (laser.emitGate && !laser.pulseModN) begin
      emitSeen <= 1'b1;
    end
  end
endmodule

//--- tb/ljs_sequencer_test.sv
// Self-checking bench for the laser job sequencer over APB.
// Assumes the package tick count; one job spans about three ticks.
`timescale 1ns/100ps
module ljs_sequencer_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ljs_pkg::ljs_apb_req_s req = '0;
  logic pready, pslverr, wantStart = 1'b0, wantStop = 1'b0;
  logic [31:0] prdata;
  logic extStart, extStop, emitSeen;
  ljs_pkg::ljs_laser_s laser;
  logic jobArmed, markActive, jobFinished, fwAlive, ledRed, ledGreen, irq;
  int num_errors = 0;
  int n_tests = 0;
  localparam int TICK_WAIT = int'(ljs_pkg::TICK_CYCLES) + 1000;

  ljs_sequencer ljs_sequencer_i (.clk(clk), .resetn(resetn), .apbReq(req),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .extStart(extStart), .extStop(extStop), .laser(laser),
    .jobArmed(jobArmed), .markActive(markActive),
    .jobFinished(jobFinished), .fwAlive(fwAlive), .ledRed(ledRed),
    .ledGreen(ledGreen), .irq(irq));
  ljs_machine_model ljs_machine_model_i (.clk(clk), .resetn(resetn),
    .wantStart(wantStart), .wantStop(wantStop), .laser(laser),
    .extStart(extStart), .extStop(extStop), .emitSeen(emitSeen));

  ////////////////////////////////////////////////////////////////////////
  // Clock and a short reset
  initial begin
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, takes the answer at that edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n = 0;
    logic rdy = 1'b0;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    while (rdy !== 1'b1 && n < 50) begin
      @(posedge clk);
      rdy = pready;
      q = prdata;
      e = pslverr;
      n++;
    end
    chk({31'h0, rdy}, 32'h1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // Read with expected data and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic expErr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, expErr});
  endtask

  // Bounded wait for an output level: 0 active, 1 finished, 2 irq, 3 gate
  task automatic wait_for(input int sel, input logic v, input int lim);
    int n = 0;
    logic s = ~v;
    while (s !== v && n < lim) begin
      @(posedge clk);
      s = (sel == 0) ? markActive : (sel == 1) ? jobFinished :
        (sel == 2) ? irq : laser.emitGate;
      n++;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask

  // Edges to let pass; outputs are then read as sampled at the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic reset_state;
    @(negedge clk);
    chk({laser.emitGate, laser.pulseModN}, 32'h1);
    chk({jobArmed, markActive, jobFinished, fwAlive}, 32'h0);
    chk({ledRed, ledGreen, irq}, 32'h0);
    rd(ljs_pkg::START_WIDTH_OFS, 32'h1, 1'b0);
    rd(8'h30, 32'h0, 1'b1);
  endtask

  task automatic static_outputs;
    wr(ljs_pkg::POWER_OFS, 32'hffff_f5a5);
    rd(ljs_pkg::POWER_OFS, 32'h0000_05a5, 1'b0);
    chk({20'h0, laser.powerLevel}, 32'h5a5);
    wr(ljs_pkg::CTRL_OFS, 32'h0000_0083);
    settle(2);
    chk({jobArmed, fwAlive, ledGreen}, 32'h3);
    wr(ljs_pkg::CTRL_OFS, 32'h0000_0020);
    settle(2);
    chk({jobArmed, fwAlive, ledRed}, 32'h1);
    wr(ljs_pkg::CTRL_OFS, 32'h0000_0040);
    settle(2);
    chk({31'h0, ledRed}, {31'h0, ljs_pkg::LFSR_SEED[0]});
  endtask

  // Stop filter while idle: a short stop is ignored, a valid one flagged
  task automatic stop_filter;
    wantStop <= 1'b1;
    settle(100);
    rd(ljs_pkg::IRQ_STAT_OFS, 32'h0, 1'b0);
    wantStop <= 1'b0;
    wr(ljs_pkg::STOP_WIDTH_OFS, 32'h0);
    wantStop <= 1'b1;
    settle(4);
    wantStop <= 1'b0;
    rd(ljs_pkg::IRQ_STAT_OFS, 32'h2, 1'b0);
    wr(ljs_pkg::IRQ_STAT_OFS, 32'h2);
    rd(ljs_pkg::IRQ_STAT_OFS, 32'h0, 1'b0);
  endtask

  // Full job: flagged start, reject, confirm, delay, marking, finish flag.
  // Zero intervals keep each step to one tick, so the run stays short.
  task automatic job_run;
    wr(ljs_pkg::START_WIDTH_OFS, 32'h0);
    wr(ljs_pkg::START_DELAY_OFS, 32'h0);
    wr(ljs_pkg::LEAD_OFS, 32'h0);
    wr(ljs_pkg::FIN_DELAY_OFS, 32'h0);
    wr(ljs_pkg::FIN_WIDTH_OFS, 32'h0);
    wr(ljs_pkg::IRQ_MASK_OFS, 32'h1);
    wr(ljs_pkg::CTRL_OFS, 32'h0000_001f);
    wantStart <= 1'b1;
    wait_for(2, 1'b1, TICK_WAIT);
    wantStart <= 1'b0;
    settle(100);
    chk({31'h0, markActive}, 32'h0);
    rd(ljs_pkg::IRQ_STAT_OFS, 32'h1, 1'b0);
    rd(ljs_pkg::STATUS_OFS, 32'h12, 1'b0);
    wr(ljs_pkg::CMD_OFS, 32'h2);
    rd(ljs_pkg::STATUS_OFS, 32'h2, 1'b0);
    wr(ljs_pkg::IRQ_STAT_OFS, 32'h1);
    wantStart <= 1'b1;
    wait_for(2, 1'b1, TICK_WAIT);
    wantStart <= 1'b0;
    wr(ljs_pkg::IRQ_MASK_OFS, 32'h0);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    wr(ljs_pkg::IRQ_STAT_OFS, 32'h1);
    wr(ljs_pkg::CMD_OFS, 32'h1);
    wait_for(0, 1'b1, 10);
    chk({31'h0, laser.emitGate}, 32'h0);
    settle(100);
    chk({31'h0, laser.emitGate}, 32'h0);
    wait_for(3, 1'b1, TICK_WAIT);
    settle(2);
    chk({laser.emitGate, laser.pulseModN}, 32'h2);
    chk({31'h0, emitSeen}, 32'h1);
    chk({31'h0, markActive}, 32'h1);
    wr(ljs_pkg::CMD_OFS, 32'h4);
    settle(100);
    chk({laser.emitGate, markActive, jobFinished}, 32'h0);
    wait_for(1, 1'b1, TICK_WAIT);
    wait_for(1, 1'b0, TICK_WAIT);
    rd(ljs_pkg::IRQ_STAT_OFS, 32'hc, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    reset_state();
    static_outputs();
    stop_filter();
    job_run();
    report_and_stop();
  end

  // Watchdog: four ticks, one more than a job should need
  initial begin
    repeat (4 * TICK_WAIT) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule
